/* File: core/scg_pkg.sv */
// Constants and types shared by the sleep clock gating block.
// Assumes a 32-bit Wishbone register window decoded by the interconnect.
package scg_pkg;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses within the block window)
	// ---------------------------------------------------------------
	localparam logic [11:0] OFF_RUN_GATE = 12'h104;
	localparam logic [11:0] OFF_SLEEP_GATE = 12'h114;
	localparam logic [11:0] OFF_DEEP_GATE = 12'h124;
	localparam logic [11:0] OFF_RUN_CFG = 12'h060;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h200;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h204;

	// ---------------------------------------------------------------
	// Field layout and reset values
	// ---------------------------------------------------------------
	localparam int NUNIT = 7;
	localparam int POS_ASYNC_SER0 = 0;
	localparam int POS_SYNC_SER0 = 4;
	localparam int POS_COUNTER0 = 16;
	localparam int POS_COUNTER1 = 17;
	localparam int POS_COUNTER2 = 18;
	localparam int POS_COMPARATOR0 = 24;
	localparam int POS_COMPARATOR1 = 25;
	localparam int UNIT_POS [NUNIT] = '{POS_ASYNC_SER0, POS_SYNC_SER0,
		POS_COUNTER0, POS_COUNTER1, POS_COUNTER2, POS_COMPARATOR0,
		POS_COMPARATOR1};
	localparam logic [31:0] GATE_WMASK = 32'h0307_0011;
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;
	localparam int ACG_POS = 27;
	localparam logic [31:0] CFG_WMASK = 32'h0000_0001 << ACG_POS;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_RUN = 2'h0,
		PWR_SLEEP = 2'h1,
		PWR_DEEP = 2'h3
	} scg_pwr_t;

	typedef enum logic {
		BUS_IDLE = 1'h0,
		BUS_ACK = 1'h1
	} scg_bus_t;

endpackage

/* File: core/scg_reg_if.sv */
// Internal register access port between bus slave and register file.
// Assumes one write strobe per accepted Wishbone write.
`timescale 1ns/1ps
interface scg_reg_if;
	logic wr;
	logic [11:0] adr;
	logic [31:0] wdat;
	logic [3:0] sel;
	logic [31:0] rdat;
	modport bus (output wr, output adr, output wdat, output sel,
		input rdat);
	modport regs (input wr, input adr, input wdat, input sel,
		output rdat);
endinterface

/* File: core/scg_wb_slave.sv */
// Classic Wishbone slave front end: one ack per request.
// Assumes the master holds a request until it samples ack.
`timescale 1ns/1ps
module scg_wb_slave (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	scg_reg_if.bus regs
);
	scg_pkg::scg_bus_t state_q;
	logic take;

	// ---------------------------------------------------------------
	// Request acceptance
	// ---------------------------------------------------------------
	// Upper address bits are left to the interconnect decoder
	assign take = ce_i && wb_cyc_i && wb_stb_i &&
		(state_q == scg_pkg::BUS_IDLE);
	assign regs.wr = take && wb_we_i;
	assign regs.adr = wb_adr_i[11:0];
	assign regs.wdat = wb_dat_i;
	assign regs.sel = wb_sel_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= scg_pkg::BUS_IDLE;
		end else if (ce_i) begin
			case (state_q)
				scg_pkg::BUS_IDLE: begin
					if (take) begin
						state_q <= scg_pkg::BUS_ACK;
					end
				end
				scg_pkg::BUS_ACK: begin
					state_q <= scg_pkg::BUS_IDLE;
				end
				default: begin
					state_q <= scg_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= take;
		end
	end

	// Read data captured with the ack, stable while ack stands
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (take && !wb_we_i) begin
			wb_dat_o <= regs.rdat;
		end
	end
endmodule

/* File: core/scg_fault_chk.sv */
// Per-unit bus fault detector for accesses to unclocked units.
// Assumes one access strobe per unit from the peripheral decoder.
`timescale 1ns/1ps
module scg_fault_chk #(
	parameter int NUNIT = 7
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [NUNIT-1:0] acc_i,
	input wire logic [NUNIT-1:0] en_i,
	output logic [NUNIT-1:0] fault_o
);
	// ---------------------------------------------------------------
	// Fault pulses
	// ---------------------------------------------------------------
	// An unclocked unit cannot answer, so the error comes from here
	for (genvar i = 0; i < NUNIT; i++) begin : g_unit
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				fault_o[i] <= 1'b0;
			end else if (ce_i) begin
				fault_o[i] <= acc_i[i] && !en_i[i];
			end
		end
	end
endmodule

/* File: core/scg_sleep_gate.sv */
// Clock gating registers for run, sleep and deep sleep, with fault irq.
// Assumes a classic Wishbone master and a power manager giving the state.
`timescale 1ns/1ps

module scg_sleep_gate (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic [1:0] pwr_state_i,
	input wire logic [scg_pkg::NUNIT-1:0] unit_acc_i,
	output logic [scg_pkg::NUNIT-1:0] unit_clk_en_o,
	output logic [scg_pkg::NUNIT-1:0] unit_fault_o,
	output logic irq_o
);
	scg_reg_if regs ();

	logic [31:0] run_q;
	logic [31:0] sleep_q;
	logic [31:0] deep_q;
	logic [31:0] cfg_q;
	logic [31:0] stat_q;
	logic [31:0] stat_d;
	logic [31:0] mask_q;
	logic [31:0] eff_gate;
	logic [31:0] fault_bits;
	logic [scg_pkg::NUNIT-1:0] en_d;
	logic auto_clock_gating_select;
	logic wr_run;
	logic wr_sleep;
	logic wr_deep;
	logic wr_cfg;
	logic wr_stat;
	logic wr_mask;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lane_wr(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel,
		input logic [31:0] wm);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r & wm;
	endfunction

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			r[8*b +: 8] = {8{sel[b]}};
		end
		return r;
	endfunction

	function automatic logic [scg_pkg::NUNIT-1:0] pick(
		input logic [31:0] v);
		logic [scg_pkg::NUNIT-1:0] r;
		r = '0;
		for (int k = 0; k < scg_pkg::NUNIT; k++) begin
			r[k] = v[scg_pkg::UNIT_POS[k]];
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Bus front end and fault detector
	// ---------------------------------------------------------------
	scg_wb_slave u_slave (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.regs(regs.bus)
	);

	scg_fault_chk #(
		.NUNIT(scg_pkg::NUNIT)
	) u_fault (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.acc_i(unit_acc_i),
		.en_i(unit_clk_en_o),
		.fault_o(unit_fault_o)
	);

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	assign wr_run = regs.wr && (regs.adr == scg_pkg::OFF_RUN_GATE);
	assign wr_sleep = regs.wr && (regs.adr == scg_pkg::OFF_SLEEP_GATE);
	assign wr_deep = regs.wr && (regs.adr == scg_pkg::OFF_DEEP_GATE);
	assign wr_cfg = regs.wr && (regs.adr == scg_pkg::OFF_RUN_CFG);
	assign wr_stat = regs.wr && (regs.adr == scg_pkg::OFF_IRQ_STAT);
	assign wr_mask = regs.wr && (regs.adr == scg_pkg::OFF_IRQ_MASK);
	assign auto_clock_gating_select = cfg_q[scg_pkg::ACG_POS];

	// ---------------------------------------------------------------
	// Gating registers
	// ---------------------------------------------------------------
	// run mode gating
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_q <= scg_pkg::GATE_RESET;
		end else if (ce_i && wr_run) begin
			run_q <= lane_wr(run_q, regs.wdat, regs.sel,
				scg_pkg::GATE_WMASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sleep_q <= scg_pkg::GATE_RESET;
		end else if (ce_i && wr_sleep) begin
			sleep_q <= lane_wr(sleep_q, regs.wdat, regs.sel,
				scg_pkg::GATE_WMASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			deep_q <= scg_pkg::GATE_RESET;
		end else if (ce_i && wr_deep) begin
			deep_q <= lane_wr(deep_q, regs.wdat, regs.sel,
				scg_pkg::GATE_WMASK);
		end
	end

	// Only the auto gating select bit is kept here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q <= scg_pkg::CFG_RESET;
		end else if (ce_i && wr_cfg) begin
			cfg_q <= lane_wr(cfg_q, regs.wdat, regs.sel,
				scg_pkg::CFG_WMASK);
		end
	end

	// ---------------------------------------------------------------
	// Read back
	// ---------------------------------------------------------------
	// stored bits, reserved zeros
	always_comb begin
		case (regs.adr)
			scg_pkg::OFF_RUN_GATE: regs.rdat = run_q;
			scg_pkg::OFF_SLEEP_GATE: regs.rdat = sleep_q;
			scg_pkg::OFF_DEEP_GATE: regs.rdat = deep_q;
			scg_pkg::OFF_RUN_CFG: regs.rdat = cfg_q;
			scg_pkg::OFF_IRQ_STAT: regs.rdat = stat_q;
			scg_pkg::OFF_IRQ_MASK: regs.rdat = mask_q;
			default: regs.rdat = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// Effective gating per power state
	// ---------------------------------------------------------------
	// low-power gating needs auto select, else run gating holds
	always_comb begin
		case (scg_pkg::scg_pwr_t'(pwr_state_i))
			scg_pkg::PWR_RUN: eff_gate = run_q;
			scg_pkg::PWR_SLEEP: eff_gate = auto_clock_gating_select ? sleep_q : run_q;
			scg_pkg::PWR_DEEP: eff_gate = auto_clock_gating_select ? deep_q : run_q;
			default: eff_gate = run_q;
		endcase
	end

	for (genvar i = 0; i < scg_pkg::NUNIT; i++) begin : g_unit
		assign en_d[i] = eff_gate[scg_pkg::UNIT_POS[i]];
		assign fault_bits[scg_pkg::UNIT_POS[i]] = unit_fault_o[i];
	end
	for (genvar j = 0; j < 32; j++) begin : g_fill
		if (!scg_pkg::GATE_WMASK[j]) begin : g_zero
			assign fault_bits[j] = 1'b0;
		end
	end

	// registered enables keep the clock gates glitch free
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unit_clk_en_o <= '0;
		end else if (ce_i) begin
			unit_clk_en_o <= en_d;
		end
	end

	// ---------------------------------------------------------------
	// Fault interrupt
	// ---------------------------------------------------------------
	// New fault beats a write-one clear in the same cycle
	always_comb begin
		stat_d = stat_q;
		if (wr_stat) begin
			stat_d = stat_q & ~(regs.wdat & lane_mask(regs.sel));
		end
		stat_d = stat_d | fault_bits;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= scg_pkg::IRQ_RESET;
		end else if (ce_i) begin
			stat_q <= stat_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= scg_pkg::IRQ_RESET;
		end else if (ce_i && wr_mask) begin
			mask_q <= lane_wr(mask_q, regs.wdat, regs.sel,
				scg_pkg::GATE_WMASK);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(stat_q & mask_q);
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_blocked;
		ce_i && |(unit_acc_i & ~unit_clk_en_o);
	endsequence

	sequence s_take(logic [11:0] off, logic we);
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o &&
			(wb_we_i == we) && (wb_adr_i[11:0] == off);
	endsequence

	sequence s_full_wr_sleep;
		s_take(scg_pkg::OFF_SLEEP_GATE, 1'b1) ##0 (wb_sel_i == 4'hf);
	endsequence

	a_reset_clear: assert property (
		$fell(rst_i) |-> (sleep_q == scg_pkg::GATE_RESET) &&
			(unit_clk_en_o == '0))
		else $error("sleep gating not clear after reset");

	a_resv_zero: assert property (
		(sleep_q & ~scg_pkg::GATE_WMASK) == 32'h0000_0000)
		else $error("reserved sleep gating bit set");

	a_sleep_gate: assert property (
		ce_i && (pwr_state_i == scg_pkg::PWR_SLEEP) && auto_clock_gating_select |=>
			unit_clk_en_o == pick($past(sleep_q)))
		else $error("sleep enables do not follow register");

	a_acg_off: assert property (
		ce_i && (pwr_state_i == scg_pkg::PWR_SLEEP) && !auto_clock_gating_select |=>
			unit_clk_en_o == pick($past(run_q)))
		else $error("sleep gating used without auto select");

	a_deep_select: assert property (
		ce_i && (pwr_state_i == scg_pkg::PWR_DEEP) && auto_clock_gating_select |=>
			unit_clk_en_o == pick($past(deep_q)))
		else $error("deep sleep register not selected");

	a_fault_gated: assert property (
		s_blocked |=> unit_fault_o ==
			$past(unit_acc_i & ~unit_clk_en_o))
		else $error("no fault for gated unit access");

	a_fault_open: assert property (
		ce_i && ((unit_acc_i & ~unit_clk_en_o) == '0) |=>
			unit_fault_o == '0)
		else $error("fault raised for clocked unit");

	a_read_back: assert property (
		s_take(scg_pkg::OFF_SLEEP_GATE, 1'b0) |=>
			wb_ack_o && (wb_dat_o == $past(sleep_q)))
		else $error("sleep gating read back wrong");

	a_write_store: assert property (
		s_full_wr_sleep |=> wb_ack_o &&
			(sleep_q == ($past(wb_dat_i) & scg_pkg::GATE_WMASK)))
		else $error("sleep gating write not stored");

	a_irq_level: assert property (
		ce_i |=> irq_o == |($past(stat_q & mask_q)))
		else $error("interrupt level wrong");

endmodule

/* File: dv/scg_unit_model.sv */
// Behavioural model of the gated peripheral units on the unit link.
// Assumes the bench raises one request bit per wanted access cycle.
`timescale 1ns/1ps
module scg_unit_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [scg_pkg::NUNIT-1:0] req_i,
	input wire logic [scg_pkg::NUNIT-1:0] en_i,
	input wire logic [scg_pkg::NUNIT-1:0] fault_i,
	output logic [scg_pkg::NUNIT-1:0] acc_o,
	output logic [scg_pkg::NUNIT-1:0] seen_o
);
	// ---------------------------------------------------------------
	// Access strobes
	// ---------------------------------------------------------------
	// one strobe per access
	always_comb begin
		acc_o = req_i;
	end

	// ---------------------------------------------------------------
	// Fault capture
	// ---------------------------------------------------------------
	// faults held until next request
	always_ff @(posedge clk_i) begin
		if (rst_i || req_i != '0) begin
			seen_o <= '0;
		end else begin
			seen_o <= seen_o | fault_i;
		end
	end
endmodule

/* File: dv/tb_sleep_mode_clock_gating.sv */
// Self-checking bench for the sleep clock gating block.
// Assumes one clock, synchronous reset and a classic Wishbone master.
`timescale 1ns/1ps
module tb_sleep_mode_clock_gating;
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic wb_ack_o, irq_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i;
	logic [1:0] pwr_state_i;
	logic [scg_pkg::NUNIT-1:0] acc, en, fault, req, seen;
	int failures, check_count;

	scg_sleep_gate dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.pwr_state_i(pwr_state_i), .unit_acc_i(acc),
		.unit_clk_en_o(en), .unit_fault_o(fault), .irq_o(irq_o));
	scg_unit_model units (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.en_i(en), .fault_i(fault), .acc_o(acc), .seen_o(seen));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task give_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Holds the request until ack is sampled, then releases it
	task wb(input logic we, input logic [11:0] adr, input logic [31:0] wd,
		input logic [3:0] sel);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {20'h00000, adr};
		wb_dat_i <= wd;
		wb_sel_i <= sel;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			failures++;
			$display("BAD wb ack expected 1 seen %b", wb_ack_o);
			give_verdict();
		end
	endtask

	task wr(input logic [11:0] adr, input logic [31:0] wd);
		wb(1'b1, adr, wd, 4'hf);
	endtask

	task rdchk(input string name, input logic [11:0] adr,
		input logic [31:0] exp);
		wb(1'b0, adr, 32'h0000_0000, 4'hf);
		chk(name, exp, rd);
	endtask

	task tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_reset;
		rdchk("sleep gate", scg_pkg::OFF_SLEEP_GATE, 32'h0000_0000);
		rdchk("run gate", scg_pkg::OFF_RUN_GATE, 32'h0000_0000);
		rdchk("deep gate", scg_pkg::OFF_DEEP_GATE, 32'h0000_0000);
		rdchk("run cfg", scg_pkg::OFF_RUN_CFG, 32'h0000_0000);
		rdchk("irq stat", scg_pkg::OFF_IRQ_STAT, 32'h0000_0000);
		rdchk("irq mask", scg_pkg::OFF_IRQ_MASK, 32'h0000_0000);
		chk("enables", 32'h0, {25'h0, en});
	endtask

	task t_reserved;
		wr(scg_pkg::OFF_SLEEP_GATE, 32'hffff_ffff);
		rdchk("sleep all", scg_pkg::OFF_SLEEP_GATE, 32'h0307_0011);
		wb(1'b1, scg_pkg::OFF_SLEEP_GATE, 32'h0000_0000, 4'h8);
		rdchk("sleep lane", scg_pkg::OFF_SLEEP_GATE, 32'h0007_0011);
		wr(12'h300, 32'hffff_ffff);
		rdchk("unmapped", 12'h300, 32'h0000_0000);
		rdchk("sleep kept", scg_pkg::OFF_SLEEP_GATE, 32'h0007_0011);
	endtask

	// Sleep bits only count once auto gating select is set
	task t_select;
		pwr_state_i <= 2'h1;
		wr(scg_pkg::OFF_RUN_GATE, 32'h0000_0001);
		wr(scg_pkg::OFF_SLEEP_GATE, 32'h0307_0011);
		wr(scg_pkg::OFF_DEEP_GATE, 32'h0001_0000);
		tick(3);
		chk("sleep no acg", 32'h01, {25'h0, en});
		wr(scg_pkg::OFF_RUN_CFG, 32'hffff_ffff);
		rdchk("run cfg", scg_pkg::OFF_RUN_CFG, 32'h0800_0000);
		tick(3);
		chk("sleep acg", 32'h7f, {25'h0, en});
		pwr_state_i <= 2'h3;
		tick(3);
		chk("deep acg", 32'h04, {25'h0, en});
		pwr_state_i <= 2'h2;
		tick(3);
		chk("state two", 32'h01, {25'h0, en});
	endtask

	task t_bits;
		pwr_state_i <= 2'h1;
		for (int i = 0; i < scg_pkg::NUNIT; i++) begin
			wr(scg_pkg::OFF_SLEEP_GATE, 32'h1 << scg_pkg::UNIT_POS[i]);
			tick(3);
			chk("unit bit", 32'h1 << i, {25'h0, en});
		end
	endtask

	// Disabled sync serial faults, enabled async serial does not
	task t_fault;
		rdchk("sleep one", scg_pkg::OFF_SLEEP_GATE, 32'h0200_0000);
		wr(scg_pkg::OFF_SLEEP_GATE, rd | 32'h0107_0011);
		wr(scg_pkg::OFF_SLEEP_GATE, rd | 32'h0107_0001);
		tick(3);
		req <= 7'h03;
		@(posedge clk_i);
		req <= 7'h00;
		tick(4);
		chk("fault units", 32'h02, {25'h0, seen});
		rdchk("irq stat", scg_pkg::OFF_IRQ_STAT, 32'h0000_0010);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wr(scg_pkg::OFF_IRQ_MASK, 32'hffff_ffff);
		tick(2);
		chk("irq up", 32'h1, {31'h0, irq_o});
		wr(scg_pkg::OFF_IRQ_STAT, 32'h0000_0010);
		tick(2);
		chk("irq down", 32'h0, {31'h0, irq_o});
		rdchk("stat clear", scg_pkg::OFF_IRQ_STAT, 32'h0000_0000);
	endtask

	// Low clock enable holds enables and faults whatever the inputs do
	task t_freeze;
		ce_i <= 1'b0;
		pwr_state_i <= 2'h0;
		req <= 7'h02;
		tick(3);
		chk("frozen en", 32'h7d, {25'h0, en});
		chk("frozen fault", 32'h0, {25'h0, fault});
		req <= 7'h00;
		ce_i <= 1'b1;
		tick(3);
		chk("thawed en", 32'h01, {25'h0, en});
	endtask

	// Reset in mid-run clears what earlier scenarios left behind
	task t_midreset;
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		chk("reset en", 32'h0, {25'h0, en});
		rdchk("sleep rst", scg_pkg::OFF_SLEEP_GATE, 32'h0000_0000);
		rdchk("run rst", scg_pkg::OFF_RUN_GATE, 32'h0000_0000);
		rdchk("cfg rst", scg_pkg::OFF_RUN_CFG, 32'h0000_0000);
		rdchk("mask rst", scg_pkg::OFF_IRQ_MASK, 32'h0000_0000);
	endtask

	initial begin
		failures = 0;
		check_count = 0;
		rst_i = 1'b1;
		ce_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 32'h0000_0000;
		wb_dat_i = 32'h0000_0000;
		wb_sel_i = 4'h0;
		pwr_state_i = 2'h0;
		req = 7'h00;
		tick(4);
		rst_i <= 1'b0;
		t_reset();
		t_reserved();
		t_select();
		t_bits();
		t_fault();
		t_freeze();
		t_midreset();
		give_verdict();
	end
endmodule
